/* src/pch_defines.svh */
/*
  Offsets, field positions and reset values for the PCI
  configuration header slice. Assumes byte offsets within a 256-byte
  configuration space, accessed as aligned double words.
*/
`ifndef PCH_DEFINES_SVH
`define PCH_DEFINES_SVH

// Byte offsets; the low two bits give the byte lane
`define PCH_OFF_LAT        8'h0D
`define PCH_OFF_IO         8'h10
`define PCH_OFF_MEM        8'h34
`define PCH_OFF_IRQ_LINE   8'h3C
`define PCH_OFF_IRQ_PIN    8'h3D
`define PCH_OFF_MAX_BUS_LATENCY     8'h3F

// Writable bits of the base registers and the latency field
`define PCH_IO_WMASK       32'hFFFFFF01
`define PCH_MEM_WMASK      32'hFFFFFE01
`define PCH_LAT_LSB        3

// Reset and constant values
`define PCH_IRQ_LINE_RST   8'h00
`define PCH_IRQ_PIN_VAL    8'h01
`define PCH_MAX_BUS_LATENCY_RST     8'h05

// Fields of the setup word from the EEPROM loader
`define PCH_EE_MAX_BUS_LATENCY_MSB  15
`define PCH_EE_MAX_BUS_LATENCY_LSB  8
`define PCH_EE_LOW1M_BIT   0
`define PCH_EE_MEMDIS_BIT  1

`endif

/* src/pch_pkg.sv */
/*
  Types shared by the configuration header slice.
  Assumes the constants header is included where numbers are needed.
*/
package pch_pkg;
  typedef logic [31:0] pch_word_t;
  typedef logic [7:0]  pch_addr_t;
  typedef logic [15:0] pch_setup_t;
  typedef enum {PCH_LD_WAIT, PCH_LD_DONE} pch_ld_e;
endpackage

/* src/pch_latency_timer.sv */
/*
  Bus-master latency counter with grant synchroniser.
  Assumes frame_start and frame_end come from the master logic on clk,
  and that the grant pin arrives asynchronously.
*/
`timescale 1ns/1ps
`include "pch_defines.svh"

module pch_latency_timer (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [4:0] lat_field,
  input  wire logic       frame_start,
  input  wire logic       frame_end,
  input  wire logic       pci_gnt_n,
  output logic            hold_expired,
  output logic            master_release
);
  import pch_pkg::*;

  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic       busy_r;
  logic       gnt_s1_r;
  logic       gnt_s2_r;
  logic       gnt_s3_r;
  logic       gnt_off_r;
  wire  [7:0] load_val = {lat_field, {`PCH_LAT_LSB{1'b0}}};
  wire        gnt_agree = (gnt_s2_r == gnt_s3_r);

  assign count_nxt = frame_start ? load_val :
                     (busy_r && count_r != 8'h00) ? count_r - 8'h01 : count_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= 8'h00;
      busy_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      busy_r  <= frame_start | (busy_r & ~frame_end);
    end
  end

  // Grant filtered: counts once two late stages agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gnt_s1_r  <= 1'b1;
      gnt_s2_r  <= 1'b1;
      gnt_s3_r  <= 1'b1;
      gnt_off_r <= 1'b1;
    end else begin
      gnt_s1_r  <= pci_gnt_n;
      gnt_s2_r  <= gnt_s1_r;
      gnt_s3_r  <= gnt_s2_r;
      gnt_off_r <= gnt_agree ? gnt_s3_r : gnt_off_r;
    end
  end

  assign hold_expired   = busy_r && (count_r == 8'h00);
  assign master_release = hold_expired && gnt_off_r;

  property p_reload;
    @(posedge clk) disable iff (!nrst)
      frame_start |=> count_r == $past(load_val);
  endproperty
  a_reload: assert property (p_reload) else $error("latency count not reloaded");

  property p_no_early_release;
    @(posedge clk) disable iff (!nrst)
      frame_start && lat_field != 5'h00 |=> !master_release [*7];
  endproperty
  a_no_early_release: assert property (p_no_early_release)
    else $error("bus released before latency expiry");

  property p_release_on_gnt;
    @(posedge clk) disable iff (!nrst)
      busy_r && count_r == 8'h00 && gnt_off_r |-> master_release;
  endproperty
  a_release_on_gnt: assert property (p_release_on_gnt)
    else $error("no release after expiry with grant removed");

  property p_hold_with_gnt;
    @(posedge clk) disable iff (!nrst)
      !gnt_off_r |-> !master_release;
  endproperty
  a_hold_with_gnt: assert property (p_hold_with_gnt) else $error("released while granted");

endmodule

/* src/pch_config_regs.sv */
/*
  Configuration header slice: interrupt line and pin, I/O and memory
  base registers, latency timer and maximum latency, with the bus-master
  latency counter. Assumes a configuration access port on clk, an EEPROM
  loader that presents its setup word once after reset, and master logic
  that pulses frame_start when it asserts FRAME#.
*/
`timescale 1ns/1ps
`include "pch_defines.svh"

//Contract
//- interrupt line byte stores and returns writes
//- interrupt pin reads constant 0x01
//- I/O base bits 31-8 writable, 7-1 zero
//- I/O bit 0 is writable valid indicator
//- latency bits 7-3 writable, 2-0 zero
//- counter loads from timer on FRAME#
//- after expiry release once grant deasserted
//- max latency read-only, EEPROM loaded, reset 0x05
//- memory base bits 31-9 writable, 8-3 zero
//- memory bit 0 is writable valid indicator
//- map type bit2 zero, bit1 from EEPROM
//- map type never reads an undefined code
//- EEPROM setup may disable memory base
module pch_config_regs (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               cfg_rd,
  input  wire logic               cfg_wr,
  input  wire pch_pkg::pch_addr_t cfg_addr,
  input  wire logic [3:0]         cfg_be,
  input  wire pch_pkg::pch_word_t cfg_wdata,
  output pch_pkg::pch_word_t      cfg_rdata,
  output logic                    cfg_ack,
  output logic                    cfg_ready,
  input  wire logic               eeprom_setup_valid,
  input  wire pch_pkg::pch_setup_t eeprom_setup_word,
  input  wire logic               frame_start,
  input  wire logic               frame_end,
  input  wire logic               pci_gnt_n,
  output logic                    hold_expired,
  output logic                    master_release,
  output logic                    io_window_valid,
  output logic                    memory_window_valid
);
  import pch_pkg::*;

  pch_ld_e    ld_r;
  pch_ld_e    ld_nxt;
  logic [7:0] irq_line_number_r;
  logic [4:0] master_hold_timer_r;
  pch_word_t  io_window_base_r;
  pch_word_t  memory_window_base_r;
  logic [7:0] max_bus_latency_r;
  logic       below_one_mb_option_r;
  logic       mem_disable_r;
  pch_word_t  rdata_r;
  logic       ack_r;
  wire pch_word_t be_mask;

  // Byte enables widened to a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      assign be_mask[gi*8 +: 8] = {8{cfg_be[gi]}};
    end
  endgenerate

  wire ld_done = (ld_r == PCH_LD_DONE);
  wire rd_tk   = cfg_rd && ld_done;
  wire wr_tk   = cfg_wr && ld_done;

  wire [5:0] dw      = cfg_addr[7:2];
  // Offsets held at full width so only their dword part is compared
  wire [7:0] off_lat = `PCH_OFF_LAT;
  wire [7:0] off_io  = `PCH_OFF_IO;
  wire [7:0] off_mem = `PCH_OFF_MEM;
  wire [7:0] off_irq = `PCH_OFF_IRQ_LINE;
  wire       sel_lat = (dw == off_lat[7:2]);
  wire       sel_io  = (dw == off_io[7:2]);
  wire       sel_mem = (dw == off_mem[7:2]);
  wire       sel_irq = (dw == off_irq[7:2]);

  wire wr_lat  = wr_tk && sel_lat && cfg_be[1];
  wire wr_io   = wr_tk && sel_io;
  wire wr_irq  = wr_tk && sel_irq && cfg_be[0];
  wire wr_mem  = wr_tk && sel_mem && !mem_disable_r;

  wire [31:0] io_m  = be_mask & `PCH_IO_WMASK;
  wire [31:0] mem_m = be_mask & `PCH_MEM_WMASK;

  // only base and indicator bits kept
  wire [31:0] io_nxt  = (io_window_base_r & ~io_m) | (cfg_wdata & io_m);
  // only base and indicator bits kept
  wire [31:0] mem_nxt = (memory_window_base_r & ~mem_m) | (cfg_wdata & mem_m);

  wire [1:0] memory_placement_type = {1'b0, below_one_mb_option_r};

  wire [31:0] mem_word = mem_disable_r ? 32'h00000000 :
                         {memory_window_base_r[31:9], 6'h00,
                          memory_placement_type, memory_window_base_r[0]};

  // count occupies bits 7-3 of its byte
  wire [31:0] lat_word = {16'h0000, master_hold_timer_r,
                          {`PCH_LAT_LSB{1'b0}}, 8'h00};

  // pin fixed, MinGnt byte not held here
  wire [31:0] irq_word = {max_bus_latency_r, 8'h00, `PCH_IRQ_PIN_VAL,
                          irq_line_number_r};

  wire [31:0] rd_word = sel_lat ? lat_word :
                        sel_io  ? io_window_base_r :
                        sel_mem ? mem_word :
                        sel_irq ? irq_word : 32'h00000000;

  // Loader: one capture, later words ignored
  always_comb begin
    ld_nxt = ld_r;
    case (ld_r)
      PCH_LD_WAIT: if (eeprom_setup_valid) begin
        ld_nxt = PCH_LD_DONE;
      end
      PCH_LD_DONE: ld_nxt = PCH_LD_DONE;
      default:     ld_nxt = PCH_LD_WAIT;
    endcase
  end

  wire ld_take = (ld_r == PCH_LD_WAIT) && eeprom_setup_valid;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ld_r                  <= PCH_LD_WAIT;
      max_bus_latency_r     <= `PCH_MAX_BUS_LATENCY_RST;
      below_one_mb_option_r <= 1'b0;
      mem_disable_r         <= 1'b0;
    end else begin
      ld_r <= ld_nxt;
      if (ld_take) begin
        max_bus_latency_r     <= eeprom_setup_word[`PCH_EE_MAX_BUS_LATENCY_MSB:`PCH_EE_MAX_BUS_LATENCY_LSB];
        below_one_mb_option_r <= eeprom_setup_word[`PCH_EE_LOW1M_BIT];
        mem_disable_r         <= eeprom_setup_word[`PCH_EE_MEMDIS_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_line_number_r   <= `PCH_IRQ_LINE_RST;
      master_hold_timer_r <= 5'h00;
    end else begin
      if (wr_irq) irq_line_number_r <= cfg_wdata[7:0];
      if (wr_lat) master_hold_timer_r <= cfg_wdata[15:11];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      io_window_base_r     <= 32'h00000000;
      memory_window_base_r <= 32'h00000000;
    end else begin
      if (wr_io)  io_window_base_r     <= io_nxt;
      if (wr_mem) memory_window_base_r <= mem_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h00000000;
      ack_r   <= 1'b0;
    end else begin
      ack_r <= rd_tk | wr_tk;
      if (rd_tk) rdata_r <= rd_word;
    end
  end

  assign cfg_rdata           = rdata_r;
  assign cfg_ack             = ack_r;
  assign cfg_ready           = ld_done;
  assign io_window_valid     = io_window_base_r[0];
  assign memory_window_valid = memory_window_base_r[0] && !mem_disable_r;

  // Grant and counter sit apart for reuse by the master
  pch_latency_timer u_timer (
    .clk            (clk),
    .nrst           (nrst),
    .lat_field      (master_hold_timer_r),
    .frame_start    (frame_start),
    .frame_end      (frame_end),
    .pci_gnt_n      (pci_gnt_n),
    .hold_expired   (hold_expired),
    .master_release (master_release)
  );

  sequence s_rd(logic sel);
    rd_tk && sel;
  endsequence

  sequence s_wr_rd(logic sel, logic lane);
    wr_tk && sel && lane ##1 rd_tk && sel;
  endsequence

  property p_irq_line_back;
    @(posedge clk) disable iff (!nrst)
      s_wr_rd(sel_irq, cfg_be[0]) |=> cfg_ack && cfg_rdata[7:0] == $past(cfg_wdata[7:0], 2);
  endproperty
  a_irq_line_back: assert property (p_irq_line_back) else $error("irq line readback wrong");

  property p_irq_pin;
    @(posedge clk) disable iff (!nrst)
      s_rd(sel_irq) |=> cfg_rdata[15:8] == 8'h01;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("irq pin not 0x01");

  property p_io_reserved;
    @(posedge clk) disable iff (!nrst)
      s_rd(sel_io) |=> cfg_ack && cfg_rdata[7:1] == 7'h00;
  endproperty
  a_io_reserved: assert property (p_io_reserved) else $error("io reserved bits set");

  property p_io_valid;
    @(posedge clk) disable iff (!nrst)
      s_wr_rd(sel_io, cfg_be[0]) |=> cfg_rdata[0] == $past(cfg_wdata[0], 2);
  endproperty
  a_io_valid: assert property (p_io_valid) else $error("io indicator readback wrong");

  property p_lat_low;
    @(posedge clk) disable iff (!nrst)
      s_wr_rd(sel_lat, cfg_be[1]) |=> cfg_rdata[15:8] == ($past(cfg_wdata[15:8], 2) & 8'hF8);
  endproperty
  a_lat_low: assert property (p_lat_low) else $error("latency timer readback wrong");

  property p_max_bus_latency_reset;
    @(posedge clk) disable iff (!nrst)
      !ld_done |-> max_bus_latency_r == 8'h05 && !cfg_ready;
  endproperty
  a_max_bus_latency_reset: assert property (p_max_bus_latency_reset) else $error("max latency reset wrong");

  property p_max_bus_latency_ro;
    @(posedge clk) disable iff (!nrst)
      ld_done && wr_tk |=> $stable(max_bus_latency_r);
  endproperty
  a_max_bus_latency_ro: assert property (p_max_bus_latency_ro) else $error("max latency changed by write");

  property p_mem_fields;
    @(posedge clk) disable iff (!nrst)
      s_rd(sel_mem) ##0 !mem_disable_r |=> cfg_rdata[8:2] == 7'h00
        && cfg_rdata[1] == below_one_mb_option_r;
  endproperty
  a_mem_fields: assert property (p_mem_fields) else $error("memory fixed bits wrong");

  property p_mem_valid;
    @(posedge clk) disable iff (!nrst)
      s_wr_rd(sel_mem, cfg_be[0]) ##0 !mem_disable_r
        |=> cfg_rdata[0] == $past(cfg_wdata[0], 2);
  endproperty
  a_mem_valid: assert property (p_mem_valid) else $error("memory indicator wrong");

  property p_map_type;
    @(posedge clk) disable iff (!nrst)
      s_rd(sel_mem) |=> !cfg_rdata[2];
  endproperty
  a_map_type: assert property (p_map_type) else $error("undefined placement type");

  property p_map_defined;
    @(posedge clk) disable iff (!nrst)
      memory_placement_type != 2'b10 && memory_placement_type != 2'b11;
  endproperty
  a_map_defined: assert property (p_map_defined) else $error("placement code undefined");

  property p_mem_disabled;
    @(posedge clk) disable iff (!nrst)
      s_rd(sel_mem) ##0 mem_disable_r |=> cfg_rdata == 32'h00000000 && !memory_window_valid;
  endproperty
  a_mem_disabled: assert property (p_mem_disabled) else $error("disabled window visible");

  property p_mem_no_write;
    @(posedge clk) disable iff (!nrst)
      mem_disable_r && cfg_wr |=> $stable(memory_window_base_r);
  endproperty
  a_mem_no_write: assert property (p_mem_no_write) else $error("disabled window written");

  property p_wait_load;
    @(posedge clk) disable iff (!nrst)
      !ld_done && (cfg_rd || cfg_wr) |=> !cfg_ack;
  endproperty
  a_wait_load: assert property (p_wait_load) else $error("access answered before load");

endmodule

/* sim/pch_far_model.sv */
/*
  Far-side model: EEPROM loader and bus arbiter grant pin.
  Assumes the bench sets the setup word and asks for grant.
*/
`timescale 1ns/1ps
module pch_far_model (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire pch_pkg::pch_setup_t setup_in,
  input  wire logic               grant_on,
  output logic                    eeprom_setup_valid,
  output pch_pkg::pch_setup_t     eeprom_setup_word,
  output logic                    pci_gnt_n
);
  import pch_pkg::*;
  logic [2:0] wait_r;
  logic       sent_r;
  logic       flip_r;
  assign eeprom_setup_valid = (wait_r == 3'h5) && !sent_r;
  // Word is garbage outside the pulse
  assign eeprom_setup_word = eeprom_setup_valid ? setup_in : (~setup_in ^ {16{flip_r}});
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_r <= 3'h0;
      sent_r <= 1'b0;
    end else if (!sent_r) begin
      wait_r <= wait_r + 3'h1;
      sent_r <= eeprom_setup_valid;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flip_r    <= 1'b0;
      pci_gnt_n <= 1'b1;
    end else begin
      flip_r    <= !flip_r;
      pci_gnt_n <= !grant_on;
    end
  end
endmodule

/* sim/pch_config_regs_tb.sv */
/*
  Self-checking bench for the configuration header slice.
  Assumes the far-side model supplies the setup word and grant.
*/
`timescale 1ns/1ps
`include "pch_defines.svh"
module pch_config_regs_tb;
  import pch_pkg::*;
  localparam time DLY = 1;
  logic       clk, nrst, cfg_rd, cfg_wr, cfg_ack, cfg_ready;
  logic       frame_start, frame_end, grant_on, pci_gnt_n;
  logic       hold_expired, master_release, io_window_valid, memory_window_valid;
  logic       eeprom_setup_valid;
  logic [3:0] cfg_be;
  pch_addr_t  cfg_addr;
  pch_word_t  cfg_wdata, cfg_rdata, q;
  pch_setup_t eeprom_setup_word, setup_in;
  logic       ack;
  int         n_fail, check_count, i;
  logic [7:0] line_vals [3] = '{8'h00, 8'h0F, 8'hFF};
  pch_far_model far (.clk(clk), .nrst(nrst), .setup_in(setup_in), .grant_on(grant_on),
    .eeprom_setup_valid(eeprom_setup_valid), .eeprom_setup_word(eeprom_setup_word),
    .pci_gnt_n(pci_gnt_n));
  pch_config_regs dut (.clk(clk), .nrst(nrst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .cfg_ready(cfg_ready), .eeprom_setup_valid(eeprom_setup_valid),
    .eeprom_setup_word(eeprom_setup_word), .frame_start(frame_start),
    .frame_end(frame_end), .pci_gnt_n(pci_gnt_n), .hold_expired(hold_expired),
    .master_release(master_release), .io_window_valid(io_window_valid),
    .memory_window_valid(memory_window_valid));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input pch_word_t got, input pch_word_t exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Entered at edge plus DLY; leaves request up for back-to-back use
  task automatic access(input logic wr, input pch_addr_t a, input logic [3:0] be,
                        input pch_word_t d);
    cfg_rd    = !wr;
    cfg_wr    = wr;
    cfg_addr  = a;
    cfg_be    = be;
    cfg_wdata = d;
    @(posedge clk);
    #DLY;
    ack = cfg_ack;
    q   = cfg_rdata;
  endtask
  task automatic wr32(input pch_addr_t a, input logic [3:0] be, input pch_word_t d);
    access(1'b1, a, be, d);
    chk1(ack, 1'b1);
  endtask
  task automatic rd_chk(input pch_addr_t a, input pch_word_t exp);
    access(1'b0, a, 4'h0, 32'h0);
    chk1(ack, 1'b1);
    check(q, exp);
  endtask
  task automatic idle();
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    @(posedge clk);
    #DLY;
  endtask
  task automatic do_reset(input pch_setup_t w);
    nrst     = 1'b0;
    setup_in = w;
    repeat (12) @(posedge clk);
    #DLY;
    nrst = 1'b1;
    access(1'b1, 8'h3C, 4'hF, 32'h00000055);
    chk1(ack, 1'b0); // early write refused
    idle();
    for (i = 0; i < 20 && cfg_ready !== 1'b1; i++) begin
      @(posedge clk);
      #DLY;
    end
    if (cfg_ready !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  initial begin
    nrst = 1'b0;
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
    frame_start = 1'b0;
    frame_end = 1'b0;
    grant_on = 1'b1;
    setup_in = 16'h3A01;
    n_fail = 0;
    check_count = 0;
    do_reset(16'h3A01);
    rd_chk(8'h3C, 32'h3A000100); // loaded values
    foreach (line_vals[k]) begin
      wr32(8'h3C, 4'h1, {24'h000000, line_vals[k]});
      rd_chk(8'h3C, {24'h3A0001, line_vals[k]});
    end
    wr32(8'h3C, 4'hF, 32'hAAAAAA0F);
    rd_chk(8'h3C, 32'h3A00010F); // pin and max latency fixed
    wr32(8'h3C, 4'h1, 32'h000000FF);
    rd_chk(8'h3C, 32'h3A0001FF); // disabled code kept
    wr32(8'h10, 4'hF, 32'hFFFFFFFF);
    rd_chk(8'h10, 32'hFFFFFF01); // I/O base bits
    chk1(io_window_valid, 1'b1); // valid flag
    wr32(8'h10, 4'h1, 32'h00000000);
    rd_chk(8'h10, 32'hFFFFFF00); // single lane
    chk1(io_window_valid, 1'b0); // flag cleared
    wr32(8'h34, 4'hF, 32'hFFFFFFFF);
    rd_chk(8'h34, 32'hFFFFFE03); // memory base bits
    chk1(memory_window_valid, 1'b1); // valid flag
    rd_chk(8'h20, 32'h00000000);
    wr32(8'h0C, 4'h2, 32'h0000FF00);
    access(1'b0, 8'h0C, 4'h0, 32'h0);
    check({24'h0, q[15:8]}, 32'h000000F8); // low bits zero
    wr32(8'h0C, 4'h2, 32'h00000F00);
    idle();
    frame_start = 1'b1;
    @(posedge clk);
    #DLY;
    frame_start = 1'b0;
    repeat (7) @(posedge clk);
    #DLY;
    chk1(hold_expired, 1'b0); // seven clocks after load, not yet
    @(posedge clk);
    #DLY;
    chk1(hold_expired, 1'b1); // expiry after eight
    chk1(master_release, 1'b0); // grant still held
    grant_on = 1'b0;
    for (i = 0; i < 8 && master_release !== 1'b1; i++) begin
      @(posedge clk);
      #DLY;
    end
    chk1(master_release, 1'b1); // release on grant loss
    frame_start = 1'b1;
    @(posedge clk);
    #DLY;
    frame_start = 1'b0;
    chk1(hold_expired, 1'b0); // reload on new frame
    frame_end = 1'b1;
    @(posedge clk);
    #DLY;
    frame_end = 1'b0;
    chk1(master_release, 1'b0); // idle master
    grant_on = 1'b1;
    do_reset(16'h3A02);
    wr32(8'h34, 4'hF, 32'hFFFFFFFF);
    rd_chk(8'h34, 32'h00000000); // disabled window
    chk1(memory_window_valid, 1'b0); // no window offered
    idle();
    report_and_stop();
  end
endmodule
